// ==== rlb_host_model.sv ====
/*
 * rlb_host_model: behavioural apb master standing in for the flash
 * controller that writes the read configuration.
 * assumes: one core_clk domain; pready comes from the bank itself.
 */
`default_nettype none
module rlb_host_model
    import rlb_pkg::*;
(
    // clock
    input  wire logic        core_clk,
    // apb master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [7:0]       paddr,
    output logic [31:0]      pwdata,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr
);
    // ------------------------------------------------------------
    // bus transfer
    // ------------------------------------------------------------
    // core_clk stays at 50 MHz, below the slowest latency limit
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // released bus shows inverted data so stale values never match
    task automatic xfer(input logic wr, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] rd,
                        output logic err);
        if (wr && (a == OFS_CFG_NV || a == OFS_CFG_V)) begin
            d[POS_RSVD] = 1'b1;
        end
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
    endtask
endmodule // rlb_host_model
`default_nettype wire

// ==== rlb_lat_decode.sv ====
/*
 * rlb_lat_decode: turns latency code, page mode and wrap code into
 * initial latency clocks and a wrap address mask.
 * assumes: purely combinational; the caller registers the results.
 */
`default_nettype none
module rlb_lat_decode
    import rlb_pkg::*;
(
    // configuration in
    input  wire rlb_cfg_t   cfg,
    // decoded values out
    output logic [5:0]      lat_clocks,
    output logic            lat_rsvd,
    output logic [5:0]      wrap_mask,
    output logic            wrap_rsvd
);
    // ----------------------------------------------------------------
    // latency: code+5 up to 16, then 20, doubled in double mode
    // ----------------------------------------------------------------
    wire [5:0] single_lat = (cfg.lat_code == LAT_CODE_20) ? LAT_TOP :
                            (LAT_BASE + {2'b00, cfg.lat_code});
    assign lat_rsvd   = (cfg.lat_code > LAT_CODE_20);
    // page_sel low selects double latency, no page-boundary gaps
    assign lat_clocks = lat_rsvd ? 6'h00 :
                        (cfg.page_sel ? single_lat
                                      : {single_lat[4:0], 1'b0});

    // ----------------------------------------------------------------
    // wrap length decode; reserved code gives a linear burst
    // ----------------------------------------------------------------
    assign wrap_rsvd = (cfg.wrap_len == WRAP_RSVD);
    assign wrap_mask = (cfg.wrap_len == WRAP_64) ? MASK_64 :
                       (cfg.wrap_len == WRAP_16) ? MASK_16 :
                       (cfg.wrap_len == WRAP_32) ? MASK_32 :
                       6'h00;
endmodule // rlb_lat_decode
`default_nettype wire

// ==== rlb_pkg.sv ====
/*
 * rlb_pkg: constants and types shared by the read latency and burst
 * configuration bank.
 * assumes: a single core_clk domain and an APB master with 32-bit data.
 */
`default_nettype none
package rlb_pkg;
    // ----------------------------------------------------------------
    // register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CFG_NV    = 8'h00;
    localparam logic [7:0] OFS_CFG_V     = 8'h04;
    localparam logic [7:0] OFS_PAGE_NV   = 8'h08;
    localparam logic [7:0] OFS_PAGE_V    = 8'h0C;
    localparam logic [7:0] OFS_STATUS    = 8'h10;
    localparam int         REG_W         = 16;

    // ----------------------------------------------------------------
    // field positions and factory values
    // ----------------------------------------------------------------
    localparam int         POS_WRAP_LO   = 0;
    localparam int         POS_STALL     = 2;
    localparam int         POS_RSVD      = 3;
    localparam int         POS_LAT_LO    = 4;
    localparam int         POS_PAGE      = 7;
    localparam logic [15:0] CFG_DEFAULT  = 16'h00BF;
    localparam logic [15:0] PAGE_DEFAULT = 16'h0080;

    // ----------------------------------------------------------------
    // wrap length codes and masks
    // ----------------------------------------------------------------
    localparam logic [1:0] WRAP_RSVD     = 2'b00;
    localparam logic [1:0] WRAP_64       = 2'b01;
    localparam logic [1:0] WRAP_16       = 2'b10;
    localparam logic [1:0] WRAP_32       = 2'b11;
    localparam logic [5:0] MASK_16       = 6'h0F;
    localparam logic [5:0] MASK_32       = 6'h1F;
    localparam logic [5:0] MASK_64       = 6'h3F;

    // ----------------------------------------------------------------
    // latency table
    // ----------------------------------------------------------------
    localparam logic [3:0] LAT_CODE_MAX  = 4'hB;
    localparam logic [3:0] LAT_CODE_20   = 4'hC;
    localparam logic [5:0] LAT_BASE      = 6'h05;
    localparam logic [5:0] LAT_TOP       = 6'h14;

    // status word positions
    localparam int         POS_ST_LAT    = 0;
    localparam int         POS_ST_MASK   = 6;
    localparam int         POS_ST_LRSVD  = 12;
    localparam int         POS_ST_WRSVD  = 13;

    // decoded view of one configuration copy
    typedef struct packed {
        logic       page_sel;
        logic [3:0] lat_code;
        logic       stall_sel;
        logic [1:0] wrap_len;
    } rlb_cfg_t;
endpackage
`default_nettype wire

// ==== rlb_read_cfg_bank.sv ====
/*
 * rlb_read_cfg_bank: read configuration bank with nonvolatile and
 * volatile copies, an APB slave, burst address wrap and strobe stall.
 * assumes: APB master on core_clk; error and burst inputs come from
 * logic on core_clk, so they are not synchronised.
 */
// What this block does
// - stall strobe on error only when select is 0
// - wrap code 01=64, 10=16, 11=32, 00 reserved
// - wrapped bursts stay in size-aligned group
// - wrap length resets to 32-byte code 11
// - codes 0..11 give 5..16 clocks, 12 gives 20
// - latency code in bits 7:4, default 1011
// - page mode 0 doubles latency, 1 single
`default_nettype none
module rlb_read_cfg_bank
    import rlb_pkg::*;
#(
    parameter int ADDR_W     = 32,
    parameter int BEAT_BYTES = 2
) (
    // clock and reset
    input  wire logic              core_clk,
    input  wire logic              srst,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic                   pready,
    output logic [31:0]            prdata,
    output logic                   pslverr,
    // hardware reload of the volatile copies
    input  wire logic              cfg_reload,
    // error detector and data strobe control
    input  wire logic              dev_error,
    output logic                   strobe_stall,
    // burst address generation
    input  wire logic              burst_start,
    input  wire logic              burst_wrapped,
    input  wire logic [ADDR_W-1:0] burst_addr,
    input  wire logic              beat_adv,
    output logic [ADDR_W-1:0]      cur_addr,
    // decoded read timing
    output logic [5:0]             init_latency,
    output logic                   latency_code_rsvd
);
    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [REG_W-1:0]  cfg_nv_r, cfg_v_r, page_nv_r, page_v_r;
    logic              load_r;
    logic [31:0]       prdata_r;
    logic              pslverr_r;
    logic              stall_r;
    logic              wrap_on_r;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [5:0]        lat_r, mask_r;
    logic              lrsvd_r, wrsvd_r;
    rlb_cfg_t          vol_cfg;
    logic [5:0]        dec_lat, dec_mask;
    logic              dec_lrsvd, dec_wrsvd;

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    wire setup_rd   = psel & ~penable & ~pwrite;
    wire access_wr  = psel & penable & pwrite;
    wire hit_cfg_nv = (paddr == OFS_CFG_NV);
    wire hit_cfg_v  = (paddr == OFS_CFG_V);
    wire hit_pg_nv  = (paddr == OFS_PAGE_NV);
    wire hit_pg_v   = (paddr == OFS_PAGE_V);
    wire hit_stat   = (paddr == OFS_STATUS);
    wire hit_any    = hit_cfg_nv | hit_cfg_v | hit_pg_nv | hit_pg_v
                    | hit_stat;
    wire [15:0] wdat = pwdata[15:0];
    wire [31:0] status_word = {18'h0_0000, wrsvd_r, lrsvd_r,
                               mask_r, lat_r};
    wire [31:0] rd_mux = hit_cfg_nv ? {16'h0000, cfg_nv_r}  :
                         hit_cfg_v  ? {16'h0000, cfg_v_r}   :
                         hit_pg_nv  ? {16'h0000, page_nv_r} :
                         hit_pg_v   ? {16'h0000, page_v_r}  :
                         hit_stat   ? status_word : 32'h0000_0000;

    // zero wait states: every access completes in its first cycle
    assign pready  = 1'b1;
    assign prdata  = prdata_r;
    assign pslverr = pslverr_r;

    // read data captured in setup so it comes straight from a flop
    always_ff @(posedge core_clk) begin
        if (srst) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (psel & ~penable) begin
            prdata_r  <= setup_rd ? rd_mux : 32'h0000_0000;
            pslverr_r <= ~hit_any;
        end
    end

    // ----------------------------------------------------------------
    // configuration copies
    // ----------------------------------------------------------------
    // nonvolatile copies hold factory values from reset in this model;
    // the reserved bit is stored as written, software keeps it at 1
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_nv_r  <= CFG_DEFAULT;
            page_nv_r <= PAGE_DEFAULT;
        end else if (access_wr) begin
            if (hit_cfg_nv) cfg_nv_r <= wdat;
            if (hit_pg_nv)  page_nv_r <= wdat;
        end
    end

    // volatile copies: loaded one cycle after reset or reload, the
    // load beats a software write landing in the same cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_v_r  <= CFG_DEFAULT;
            page_v_r <= PAGE_DEFAULT;
            load_r   <= 1'b1;
        end else begin
            load_r <= cfg_reload;
            if (load_r) begin
                cfg_v_r  <= cfg_nv_r;
                page_v_r <= page_nv_r;
            end else if (access_wr) begin
                if (hit_cfg_v) cfg_v_r <= wdat;
                if (hit_pg_v)  page_v_r <= wdat;
            end
        end
    end

    // only the volatile copy steers read behaviour
    assign vol_cfg.page_sel  = page_v_r[POS_PAGE];
    assign vol_cfg.lat_code  = cfg_v_r[POS_LAT_LO +: 4];
    assign vol_cfg.stall_sel = cfg_v_r[POS_STALL];
    assign vol_cfg.wrap_len  = cfg_v_r[POS_WRAP_LO +: 2];

    rlb_lat_decode u_dec (
        .cfg        (vol_cfg),
        .lat_clocks (dec_lat),
        .lat_rsvd   (dec_lrsvd),
        .wrap_mask  (dec_mask),
        .wrap_rsvd  (dec_wrsvd)
    );

    // decoded timing registered once per cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            lat_r   <= 6'h00;
            mask_r  <= 6'h00;
            lrsvd_r <= 1'b0;
            wrsvd_r <= 1'b0;
        end else begin
            lat_r   <= dec_lat;
            mask_r  <= dec_mask;
            lrsvd_r <= dec_lrsvd;
            wrsvd_r <= dec_wrsvd;
        end
    end
    assign init_latency      = lat_r;
    assign latency_code_rsvd = lrsvd_r;

    // ----------------------------------------------------------------
    // data strobe stall
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) stall_r <= 1'b0;
        else      stall_r <= dev_error & ~vol_cfg.stall_sel;
    end
    assign strobe_stall = stall_r;

    // ----------------------------------------------------------------
    // burst address: low bits roll inside the aligned group
    // ----------------------------------------------------------------
    // linear bursts and the reserved wrap code take an all-ones mask, so
    // every address bit gets the plain increment instead of freezing
    wire              wrap_act = wrap_on_r & ~wrsvd_r;
    wire [ADDR_W-1:0] mask_ext = wrap_act
                               ? {{(ADDR_W-6){1'b0}}, mask_r}
                               : {ADDR_W{1'b1}};
    wire [ADDR_W-1:0] addr_inc = addr_r + ADDR_W'(BEAT_BYTES);
    assign addr_nxt = (addr_r & ~mask_ext) | (addr_inc & mask_ext);

    always_ff @(posedge core_clk) begin
        if (srst) begin
            addr_r    <= '0;
            wrap_on_r <= 1'b0;
        end else if (burst_start) begin
            addr_r    <= burst_addr;
            wrap_on_r <= burst_wrapped;
        end else if (beat_adv) begin
            addr_r    <= addr_nxt;
        end
    end
    assign cur_addr = addr_r;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    chk_stall_cause: assert property (
        strobe_stall |-> $past(dev_error) && !$past(cfg_v_r[POS_STALL]))
        else $error("strobe stalled without enabled error");
    chk_stall_taken: assert property (
        dev_error && !cfg_v_r[POS_STALL] |=> strobe_stall)
        else $error("error did not stall strobe");
    chk_wrap_sixteen: assert property (
        cfg_v_r[1:0] == WRAP_16 |=> mask_r == MASK_16)
        else $error("wrap code 10 not 16 bytes");
    chk_wrap_group: assert property (
        wrap_on_r && beat_adv && !burst_start
        |=> (addr_r & ~mask_ext) == $past(addr_r & ~mask_ext))
        else $error("wrapped burst left its group");
    chk_wrap_default: assert property (
        $past(srst) |-> cfg_v_r[1:0] == WRAP_32)
        else $error("wrap length not 32 after reset");
    chk_lat_single: assert property (
        page_v_r[POS_PAGE] && cfg_v_r[7:4] <= LAT_CODE_MAX
        |=> lat_r == LAT_BASE + {2'b00, $past(cfg_v_r[7:4])})
        else $error("single latency wrong");
    chk_lat_double: assert property (
        !page_v_r[POS_PAGE] && cfg_v_r[7:4] == LAT_CODE_20
        |=> lat_r == 6'h28)
        else $error("double latency of code 12 not 40");
    chk_load_copy: assert property (
        load_r |=> cfg_v_r == $past(cfg_nv_r)
                && page_v_r == $past(page_nv_r))
        else $error("volatile copy not loaded");
    chk_lat_reset: assert property (
        $past(srst, 2) && !$past(srst) |-> lat_r == 6'h10)
        else $error("default latency not 16 clocks");
endmodule // rlb_read_cfg_bank
`default_nettype wire

// ==== tb.sv ====
/*
 * tb: self-checking bench for the read configuration bank.
 * assumes: rlb_host_model drives the apb side; the bench drives burst,
 * error and reload inputs at rising edges.
 */
`default_nettype none
module tb
    import rlb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic [3:0] code;
        logic       page;
        logic       rsvd;
        logic [5:0] lat;
    } rlb_row_t;

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic        core_clk = 1'b0;
    logic        srst = 1'b1;
    wire         psel, penable, pwrite;
    wire  [7:0]  paddr;
    wire  [31:0] pwdata;
    logic        pready, pslverr, strobe_stall, latency_code_rsvd;
    logic [31:0] prdata, cur_addr, rd, ex;
    logic        cfg_reload = 1'b0, dev_error = 1'b0, err;
    logic        burst_start = 1'b0, burst_wrapped = 1'b0;
    logic        beat_adv = 1'b0;
    logic [31:0] burst_addr = 32'h0000_013E;
    logic [5:0]  init_latency;
    int          miscompares = 0, total_checks = 0, cycles = 0;
    logic [5:0]  msk [4] = '{6'h00, 6'h3F, 6'h0F, 6'h1F};
    rlb_row_t    rows [10] = '{
        '{4'h0, 1'b1, 1'b0, 6'h05}, '{4'h1, 1'b1, 1'b0, 6'h06},
        '{4'hB, 1'b1, 1'b0, 6'h10}, '{4'hC, 1'b1, 1'b0, 6'h14},
        '{4'hD, 1'b1, 1'b1, 6'h00}, '{4'hF, 1'b1, 1'b1, 6'h00},
        '{4'h0, 1'b0, 1'b0, 6'h0A}, '{4'hB, 1'b0, 1'b0, 6'h20},
        '{4'hC, 1'b0, 1'b0, 6'h28}, '{4'hE, 1'b0, 1'b1, 6'h00}};

    always #10 core_clk = ~core_clk;

    rlb_read_cfg_bank u_rlb_read_cfg_bank (
        .core_clk(core_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .cfg_reload(cfg_reload),
        .dev_error(dev_error), .strobe_stall(strobe_stall),
        .burst_start(burst_start), .burst_wrapped(burst_wrapped),
        .burst_addr(burst_addr), .beat_adv(beat_adv),
        .cur_addr(cur_addr), .init_latency(init_latency),
        .latency_code_rsvd(latency_code_rsvd));

    rlb_host_model host (
        .core_clk(core_clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        host.xfer(1'b1, a, d, rd, err);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        host.xfer(1'b0, a, 32'h0000_0000, rd, err);
        cmp(rd, exp);
    endtask

    // settle two edges, then look away from the edge
    task automatic settle();
        repeat (2) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    // one start or advance pulse; cur_addr is looked at after it lands
    task automatic beat(input logic st);
        @(posedge core_clk);
        burst_start <= st;
        beat_adv    <= ~st;
        @(posedge core_clk);
        burst_start <= 1'b0;
        beat_adv    <= 1'b0;
        @(negedge core_clk);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // hang guard well above the few hundred cycles the run needs
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge core_clk);
        srst <= 1'b0;
        settle();
        cmp({26'h0, init_latency}, 32'h0000_0010);
        cmp({31'h0, pready}, 32'h0000_0001);
        rdc(OFS_CFG_NV, 32'h0000_00BF);
        rdc(OFS_CFG_V, 32'h0000_00BF);
        rdc(OFS_PAGE_V, 32'h0000_0080);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(OFS_PAGE_V, {24'h0, rows[i].page, 7'h00});
            wr(OFS_CFG_V, {24'h0, rows[i].code, 4'hF});
            settle();
            cmp({26'h0, init_latency}, {26'h0, rows[i].lat});
            cmp({31'h0, latency_code_rsvd}, {31'h0, rows[i].rsvd});
        end
        $display("latency table test done");
        @(posedge core_clk);
        burst_wrapped <= 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CFG_V, {24'h0, 4'hB, 2'b11, c[1:0]});
            settle();
            rdc(OFS_STATUS, {18'h0, c == 0, 1'b0, msk[c], 6'h20});
            beat(1'b1);
            ex = 32'h0000_013E;
            cmp(cur_addr, ex);
            repeat (2) begin
                beat(1'b0);
                // code 00 runs linear, the others roll under their mask
                if (msk[c] == 6'h00) ex = ex + 32'h0000_0002;
                else ex = (ex & ~{26'h0, msk[c]})
                        | ((ex + 32'h0000_0002) & {26'h0, msk[c]});
                cmp(cur_addr, ex);
            end
        end
        // a linear burst ignores the wrap code and crosses the group
        @(posedge core_clk);
        burst_wrapped <= 1'b0;
        beat(1'b1);
        beat(1'b0);
        cmp(cur_addr, 32'h0000_0140);
        $display("wrap test done");
        @(posedge core_clk);
        dev_error <= 1'b1;
        settle();
        cmp({31'h0, strobe_stall}, 32'h0000_0000);
        wr(OFS_CFG_V, 32'h0000_00BB);
        settle();
        cmp({31'h0, strobe_stall}, 32'h0000_0001);
        @(posedge core_clk);
        dev_error <= 1'b0;
        $display("stall test done");
        wr(OFS_CFG_NV, 32'h0000_000F);
        rdc(OFS_CFG_V, 32'h0000_00BB);
        @(posedge core_clk);
        cfg_reload <= 1'b1;
        @(posedge core_clk);
        cfg_reload <= 1'b0;
        settle();
        cmp({26'h0, init_latency}, 32'h0000_0005);
        rdc(OFS_CFG_V, 32'h0000_000F);
        host.xfer(1'b0, 8'h20, 32'h0000_0000, rd, err);
        cmp({31'h0, err}, 32'h0000_0001);
        cmp(rd, 32'h0000_0000);
        $display("reload and unmapped test done");
        // second reset in mid-run brings factory values back
        @(posedge core_clk);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        srst <= 1'b0;
        settle();
        cmp({26'h0, init_latency}, 32'h0000_0010);
        cmp(cur_addr, 32'h0000_0000);
        rdc(OFS_CFG_V, 32'h0000_00BF);
        $display("mid-run reset test done");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
